/* File: include/strap_pkg.sv */
// Constants and types shared by the strap capture logic
//
// Overview of operation
// - Five-bit base address strap is sampled at reset and latched; any value accepted.
// - Address bit reads one when pulled up, zero when pulled down.
// - Four port addresses are base plus zero, one, two and three.
// - Each indicator pin is also its own polarity strap, fixed at strap loading.
// - Low strap level gives polarity one: indicator driven active high.
// - High strap level gives polarity zero: indicator driven active low.
// - Five-bit functional mode is latched at reset and applied to all four ports.
// - Style strap zero selects tri-colour, one individual; same for all eight indicators.
// - Straps are captured when the pin reset is released, not while it is held.
package strap_pkg;

  localparam int ADDR_W = 5;
  localparam int MODE_W = 5;
  localparam int NUM_PORTS = 4;
  localparam int NUM_IND = 8;

  localparam logic [ADDR_W-1:0] ADDR_MAX_BASE = 5'h1C;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [NUM_IND-1:0] POL_RST = 8'h00;
  localparam logic BCAST_DIS_RST = 1'b1;
  localparam logic STYLE_RST = 1'b0;

  // Cycles the pins settle in the synchroniser after reset release
  localparam int SETTLE_CYCLES = 3;
  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYCLES - 1);

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [MODE_W-1:0] mode_t;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b001,
    ST_SETTLE = 3'b010,
    ST_DONE   = 3'b100
  } load_state_e;

  // Port address = base + port index, wrapping in five bits
  function automatic addr_t port_addr(input addr_t base, input int unsigned idx);
    port_addr = addr_t'(base + addr_t'(idx));
  endfunction : port_addr

endpackage : strap_pkg

/* File: include/strap_if.sv */
// Interface carrying synchronised strap levels between capture modules
`timescale 1ns/100ps
`default_nettype none
interface strap_if;
  import strap_pkg::*;
  addr_t              base_addr;
  mode_t              mode;
  logic               bcast;
  logic               style;
  logic [NUM_IND-1:0] ind_level;

  modport src (output base_addr, output mode, output bcast, output style, output ind_level);
  modport dst (input base_addr, input mode, input bcast, input style, input ind_level);
endinterface : strap_if
`default_nettype wire

/* File: rtl/strap_sync.sv */
// Two-stage synchroniser for all strap pins
`timescale 1ns/100ps
`default_nettype none
module strap_sync
  import strap_pkg::*;
(
  // Clock
  input  wire logic                clock,
  // Raw pins
  input  wire logic [ADDR_W-1:0]   base_pin,
  input  wire logic [MODE_W-1:0]   mode_pin,
  input  wire logic                bcast_pin,
  input  wire logic                style_pin,
  input  wire logic [NUM_IND-1:0]  ind_pin,
  // Synchronised levels
  strap_if.src                     sync
);
  import strap_pkg::*;

  localparam int W = ADDR_W + MODE_W + 2 + NUM_IND;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // No reset: these only ever carry pin levels
  always_comb begin
    state_d        = state_q;
    state_d.meta   = {base_pin, mode_pin, bcast_pin, style_pin, ind_pin};
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clock) begin
    state_q <= state_d;
  end

  assign {sync.base_addr, sync.mode, sync.bcast, sync.style, sync.ind_level} = state_q.stable;

endmodule : strap_sync
`default_nettype wire

/* File: rtl/strap_config_latch.sv */
// Strap capture at reset release, holding chip configuration
`timescale 1ns/100ps
`default_nettype none
module strap_config_latch
  import strap_pkg::*;
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // Strap pins, input side
  input  wire logic [ADDR_W-1:0]            port_base_addr_strap,
  input  wire logic [MODE_W-1:0]            mode_strap,
  input  wire logic                         broadcast_access_strap,
  input  wire logic                         indicator_style_strap,
  input  wire logic [NUM_IND-1:0]           indicator_pin_in,
  // Indicator drive from the rest of the chip, active-high request
  input  wire logic [NUM_IND-1:0]           indicator_on,
  // Indicator pin drive
  output var logic [NUM_IND-1:0]            indicator_pin_out,
  output var logic [NUM_IND-1:0]            indicator_pin_oe,
  // Captured configuration
  output var logic                          straps_valid,
  output var strap_pkg::addr_t              base_addr,
  output var logic [NUM_PORTS*ADDR_W-1:0]   port_addrs,
  output var strap_pkg::mode_t              func_mode,
  output var logic                          broadcast_enable,
  output var logic                          style_individual,
  output var logic [NUM_IND-1:0]            indicator_polarity_strap
);
  import strap_pkg::*;

  strap_if sync ();

  strap_sync u_sync (
    .clock     (clock),
    .base_pin  (port_base_addr_strap),
    .mode_pin  (mode_strap),
    .bcast_pin (broadcast_access_strap),
    .style_pin (indicator_style_strap),
    .ind_pin   (indicator_pin_in),
    .sync      (sync.src)
  );

  typedef struct packed {
    load_state_e                  st;
    logic [1:0]                   cnt;
    logic                         valid;
    addr_t                        base;
    logic [NUM_PORTS*ADDR_W-1:0]  ports;
    mode_t                        mode;
    logic                         bcast_en;
    logic                         style;
    logic [NUM_IND-1:0]           pol;
    logic [NUM_IND-1:0]           pin_out;
    logic [NUM_IND-1:0]           pin_oe;
  } latch_s;

  latch_s state_q;
  latch_s state_d;

  // ----------------------------------------
  // Capture sequence
  // ----------------------------------------
  // Pins are sampled after release, once the synchroniser holds post-release levels.
  always_comb begin
    state_d = state_q;
    case (state_q.st)
      ST_RESET: begin
        state_d.st  = ST_SETTLE;
        state_d.cnt = 2'h0;
      end
      ST_SETTLE: begin
        if (state_q.cnt == SETTLE_LAST) begin
          state_d.st       = ST_DONE;
          state_d.valid    = 1'b1;
          state_d.base     = sync.base_addr;
          // Offsets wrap in five bits; keeping the base at or below 1C is left to the board
          for (int i = 0; i < NUM_PORTS; i++) begin
            state_d.ports[i*ADDR_W +: ADDR_W] = port_addr(sync.base_addr, i);
          end
          state_d.mode     = sync.mode;
          state_d.bcast_en = ~sync.bcast;
          state_d.style    = sync.style;
          state_d.pol      = ~sync.ind_level;
        end else begin
          state_d.cnt = 2'(state_q.cnt + 2'h1);
        end
      end
      ST_DONE: begin
        // Captured fields held; only the pin drive follows indicator_on
        state_d.pin_oe  = {NUM_IND{1'b1}};
        state_d.pin_out = ~(indicator_on ^ state_q.pol);
      end
      default: begin
        state_d.st = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q.st       <= ST_RESET;
      state_q.cnt      <= 2'h0;
      state_q.valid    <= 1'b0;
      state_q.base     <= ADDR_RST;
      state_q.ports    <= '0;
      state_q.mode     <= MODE_RST;
      state_q.bcast_en <= ~BCAST_DIS_RST;
      state_q.style    <= STYLE_RST;
      state_q.pol      <= POL_RST;
      state_q.pin_out  <= '0;
      state_q.pin_oe   <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign straps_valid             = state_q.valid;
  assign base_addr                = state_q.base;
  assign port_addrs               = state_q.ports;
  assign func_mode                = state_q.mode;
  assign broadcast_enable         = state_q.bcast_en;
  assign style_individual         = state_q.style;
  assign indicator_polarity_strap = state_q.pol;
  assign indicator_pin_out        = state_q.pin_out;
  assign indicator_pin_oe         = state_q.pin_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  addr_t base_hold_q;
  always_ff @(posedge clock) begin
    base_hold_q <= state_q.base;
  end

  capture_time_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> !straps_valid [*4] ##1 straps_valid)
    else $error("straps not captured on time after reset release");

  addr_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_valid && $past(straps_valid) |-> base_addr == base_hold_q)
    else $error("latched base address changed");

  cfg_stable_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_valid && $past(straps_valid) |-> $stable(func_mode) && $stable(indicator_polarity_strap)
      && $stable(broadcast_enable) && $stable(style_individual))
    else $error("latched configuration changed");

  port_offset_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_valid |-> port_addrs[19:15] == addr_t'(base_addr + 5'h03)
      && port_addrs[4:0] == base_addr)
    else $error("port address offsets wrong");

  drive_after_a: assert property (@(posedge clock) disable iff (sys_rst)
    |indicator_pin_oe |-> straps_valid && $past(straps_valid))
    else $error("indicator driven before capture");

  polarity_a: assert property (@(posedge clock) disable iff (sys_rst)
    indicator_pin_oe[0] && indicator_polarity_strap[0] && $past(indicator_on[0])
      && $past(straps_valid) |-> indicator_pin_out[0])
    else $error("active high indicator not driven high");

  polarity_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    indicator_pin_oe[0] && !indicator_polarity_strap[0] && $past(indicator_on[0])
      && $past(straps_valid) |-> !indicator_pin_out[0])
    else $error("active low indicator not driven low");

  capture_val_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(straps_valid) |-> base_addr == $past(sync.base_addr)
      && broadcast_enable == !$past(sync.bcast) && func_mode == $past(sync.mode))
    else $error("captured strap value mismatch");

  port_mid_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_valid |-> port_addrs[9:5] == addr_t'(base_addr + 5'h01)
      && port_addrs[14:10] == addr_t'(base_addr + 5'h02))
    else $error("middle port addresses wrong");

  polarity_cap_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(straps_valid) |-> indicator_polarity_strap == ~$past(sync.ind_level)
      && style_individual == $past(sync.style))
    else $error("captured polarity or style mismatch");

  hold_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    !straps_valid |-> indicator_pin_oe == '0 && indicator_pin_out == '0)
    else $error("indicator pins driven before capture");

  oe_full_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_valid && $past(straps_valid) |-> &indicator_pin_oe)
    else $error("indicator pins not all driven after capture");

  active_high_all_a: assert property (@(posedge clock) disable iff (sys_rst)
    &indicator_pin_oe |-> (indicator_pin_out & indicator_polarity_strap)
      == ($past(indicator_on) & indicator_polarity_strap))
    else $error("active high indicators do not follow request");

  active_low_all_a: assert property (@(posedge clock) disable iff (sys_rst)
    &indicator_pin_oe |-> (indicator_pin_out | indicator_polarity_strap)
      == (~$past(indicator_on) | indicator_polarity_strap))
    else $error("active low indicators do not follow inverted request");

  // Checked without a disable so that the reset values themselves are watched
  reset_state_a: assert property (@(posedge clock)
    $past(sys_rst) |-> !straps_valid && indicator_pin_oe == '0 && base_addr == ADDR_RST
      && func_mode == MODE_RST && indicator_polarity_strap == POL_RST)
    else $error("outputs not at reset values during reset");

  valid_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(straps_valid) && !$past(sys_rst) |-> straps_valid)
    else $error("capture flag dropped without reset");

endmodule : strap_config_latch
`default_nettype wire

/* File: dv/strap_board.sv */
// Board model: strap pull resistors on every strap pin
`timescale 1ns/100ps
`default_nettype none
module strap_board
  import strap_pkg::*;
(
  // Pull level fitted on each pin
  input  wire logic [ADDR_W-1:0]  base_pull,
  input  wire logic [MODE_W-1:0]  mode_pull,
  input  wire logic               bcast_pull,
  input  wire logic               style_pull,
  input  wire logic [NUM_IND-1:0] ind_pull,
  // Device drive of the shared indicator pins
  input  wire logic [NUM_IND-1:0] ind_out,
  input  wire logic [NUM_IND-1:0] ind_oe,
  // Levels seen at the pins
  output logic [ADDR_W-1:0]       base_pin,
  output logic [MODE_W-1:0]       mode_pin,
  output logic                    bcast_pin,
  output logic                    style_pin,
  output logic [NUM_IND-1:0]      ind_pin
);
  assign base_pin  = base_pull;
  assign mode_pin  = mode_pull;
  assign bcast_pin = bcast_pull;
  assign style_pin = style_pull;
  // Device drive overrides the weak pull once enabled
  assign ind_pin = (ind_oe & ind_out) | (~ind_oe & ind_pull);
endmodule : strap_board
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the strap capture block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import strap_pkg::*;
  logic clock, sys_rst;
  addr_t base_pull;
  mode_t mode_pull;
  logic bcast_pull, style_pull, straps_valid, broadcast_enable, style_individual;
  logic [NUM_IND-1:0] ind_pull, indicator_on, pin_out, pin_oe, pol;
  logic [NUM_IND-1:0] ind_pin;
  addr_t base_pin, base_addr;
  mode_t mode_pin, func_mode;
  logic bcast_pin, style_pin;
  logic [NUM_PORTS*ADDR_W-1:0] port_addrs, exp_pa;
  int errors, cmp_count;

  strap_board i_strap_board (.base_pull(base_pull), .mode_pull(mode_pull),
    .bcast_pull(bcast_pull), .style_pull(style_pull), .ind_pull(ind_pull),
    .ind_out(pin_out), .ind_oe(pin_oe), .base_pin(base_pin), .mode_pin(mode_pin),
    .bcast_pin(bcast_pin), .style_pin(style_pin), .ind_pin(ind_pin));

  strap_config_latch i_strap_config_latch (.clock(clock), .sys_rst(sys_rst),
    .port_base_addr_strap(base_pin), .mode_strap(mode_pin),
    .broadcast_access_strap(bcast_pin), .indicator_style_strap(style_pin),
    .indicator_pin_in(ind_pin), .indicator_on(indicator_on),
    .indicator_pin_out(pin_out), .indicator_pin_oe(pin_oe), .straps_valid(straps_valid),
    .base_addr(base_addr), .port_addrs(port_addrs), .func_mode(func_mode),
    .broadcast_enable(broadcast_enable), .style_individual(style_individual),
    .indicator_polarity_strap(pol));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Pulls start inverted mid-reset so only the level at release can win
  task automatic do_reset(input addr_t b, input mode_t m, input logic bc, input logic st,
                          input logic [NUM_IND-1:0] ind);
    int n;
    @(posedge clock);
    sys_rst <= 1'b1;
    {base_pull, mode_pull, bcast_pull, style_pull, ind_pull} <= ~{b, m, bc, st, ind};
    repeat (6) @(posedge clock);
    {base_pull, mode_pull, bcast_pull, style_pull, ind_pull} <= {b, m, bc, st, ind};
    repeat (6) @(posedge clock);
    #1 check(straps_valid, 1'b0);
    check(pin_oe, 8'h00);
    @(posedge clock);
    sys_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
      if (!straps_valid) check(pin_oe, 8'h00);
    end while (straps_valid !== 1'b1 && n < 10);
    check(n, SETTLE_CYCLES + 1);
    @(posedge clock);
    #1 check(pin_oe, 8'hFF);
  endtask : do_reset

  task automatic check_cfg(input addr_t b, input mode_t m, input logic bc, input logic st,
                           input logic [NUM_IND-1:0] ind);
    for (int i = 0; i < NUM_PORTS; i++) exp_pa[i*ADDR_W +: ADDR_W] = addr_t'(b + addr_t'(i));
    check(base_addr, b);
    check(port_addrs, exp_pa);
    check(func_mode, m);
    check(broadcast_enable, 1'(~bc));
    check(style_individual, st);
    check(pol, NUM_IND'(~ind));
  endtask : check_cfg

  // Output follows request where the strap was low, inverted where it was high
  task automatic drive_ind(input logic [NUM_IND-1:0] on, input logic [NUM_IND-1:0] ind);
    @(posedge clock);
    indicator_on <= on;
    @(posedge clock);
    #1 check(pin_out, on ^ ind);
  endtask : drive_ind

  // ----------------------------------------
  // Clock, stimulus, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    indicator_on = 8'h00;
    {base_pull, mode_pull, bcast_pull, style_pull, ind_pull} = '0;
    // Base kept at or below 1C by the board
    do_reset(5'h1C, 5'h11, 1'b0, 1'b1, 8'hA5);
    check_cfg(5'h1C, 5'h11, 1'b0, 1'b1, 8'hA5);
    drive_ind(8'h00, 8'hA5);
    drive_ind(8'hFF, 8'hA5);
    drive_ind(8'h3C, 8'hA5);
    @(posedge clock);
    {base_pull, mode_pull, bcast_pull, style_pull, ind_pull} <= '0;
    repeat (8) @(posedge clock);
    #1 check_cfg(5'h1C, 5'h11, 1'b0, 1'b1, 8'hA5);
    do_reset(5'h00, 5'h0A, 1'b1, 1'b0, 8'h5A);
    check_cfg(5'h00, 5'h0A, 1'b1, 1'b0, 8'h5A);
    drive_ind(8'hC3, 8'h5A);
    drive_ind(8'h00, 8'h5A);
    finish_test();
  end

  initial begin
    #(40 * 2000);
    errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
